//--- src/crf_core_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - adding x, inverted y, carry in set gives x-y; carry out means x>=y
// - same with carry in clear gives x-y-1; carry out means x>y
// - thirteen 32-bit general registers plus stack pointer, link and program counter
// - reset loads the stack pointer with the main stack top
// - link register takes branch-with-link return value and exception entry value
// - reset loads the program counter with the reset handler start
// - indices 0-12 general, 13 stack, 14 link; 15 reads pc, never written
// - plain branch clears address bit 0, execution state bit untouched
// - interworking branch in handler mode with top nibble ones starts exception return
// - otherwise interworking copies bit 0 to state bit; zero faults next instruction
// - interworking with link always copies bit 0, never checks exception return
// - load writes act as interworking branch, arithmetic writes as plain branch
// - negative flag takes result bit 31 on flag update
// - zero flag set when whole result is zero
// - carry flag takes the carry condition
// - overflow flag takes the overflow condition
// - only the compact instruction state is valid for execution
// - faults reported with their instruction; interrupts asynchronous to program flow
// - no coprocessor interface; coprocessor instructions are unsupported
module crf_core_regs
  import crf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic link_en,
  input wire logic [31:0] link_val,
  input wire logic exc_entry_en,
  input wire logic [31:0] exc_lr_val,
  input wire logic pc_wr_en,
  input wire crf_pcw_type pc_wr_kind,
  input wire logic [31:0] pc_wr_addr,
  input wire logic handler_mode,
  input wire logic add_en,
  input wire crf_add_req_type add_req,
  input wire logic add_set_flags,
  input wire logic logic_flag_en,
  input wire logic [31:0] logic_res,
  input wire logic logic_c,
  input wire logic instr_issue,
  input wire logic instr_is_cp,
  input wire logic irq_in,
  output logic [31:0] program_counter_reg,
  output logic [31:0] stack_pointer_reg,
  output logic [31:0] return_link_reg,
  output logic [3:0] program_status_flags,
  output logic execution_state_bit,
  output logic [31:0] add_res,
  output logic add_c,
  output logic add_v,
  output logic exception_return_start,
  output logic [27:0] exc_ret_addr,
  output logic hard_fault_exception,
  output logic undef_fault,
  output logic irq_pending
);

  // ********************************
  // helpers
  // ********************************
  function automatic logic [33:0] add_carry_function(input logic [31:0] x, input logic [31:0] y,
                                                     input logic cin);
    logic [32:0] sum;
    logic ovf;
    sum = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
    ovf = (x[31] == y[31]) && (sum[31] != x[31]);
    return {sum[32], ovf, sum[31:0]};
  endfunction

  function automatic logic [31:0] core_read(input crf_state_type s, input logic [3:0] idx);
    // index 15 is the program counter, readable only
    if (idx == CRF_IDX_PC) begin
      return s.pc;
    end
    return s.regs[idx];
  endfunction

  function automatic logic map_hit(input logic [11:0] a);
    return (a == CRF_OFS_FLAGS) || (a == CRF_OFS_PC) || (a == CRF_OFS_STATE) ||
           (a[11:6] == CRF_OFS_CORE[11:6] && a[1:0] == 2'h0);
  endfunction

  crf_state_type r;
  crf_state_type n;
  logic [33:0] add_out;
  logic [31:0] pc_tgt;

  always_comb begin
    add_out = add_carry_function(add_req.x, add_req.inv_y ? ~add_req.y : add_req.y, add_req.cin);
    pc_tgt = {pc_wr_addr[31:1], 1'b0};
    n = r;
    n.exc_ret = 1'b0;
    n.hard_fault = 1'b0;
    n.undef_fault = 1'b0;

    // ********************************
    // register writes
    // ********************************
    if (wr_en && wr_idx != CRF_IDX_PC) begin
      n.regs[wr_idx] = wr_data;
    end
    if (link_en) begin
      n.regs[CRF_IDX_LR] = link_val;
    end
    // exception entry beats a same-cycle link update
    if (exc_entry_en) begin
      n.regs[CRF_IDX_LR] = exc_lr_val;
    end
    n.rd_data = core_read(r, rd_idx);

    // ********************************
    // program counter writes
    // ********************************
    if (pc_wr_en) begin
      unique case (pc_wr_kind)
        PCW_PLAIN, PCW_ALU: begin
          n.pc = pc_tgt;
        end
        PCW_BX, PCW_LOAD: begin
          if (handler_mode && pc_wr_addr[31:28] == CRF_EXC_NIB) begin
            n.exc_ret = 1'b1;
            n.exc_ret_addr = pc_wr_addr[27:0];
          end else begin
            n.t = pc_wr_addr[0];
            n.pc = pc_tgt;
          end
        end
        PCW_BLX: begin
          n.t = pc_wr_addr[0];
          n.pc = pc_tgt;
        end
        default: begin
          n.pc = r.pc;
        end
      endcase
    end

    // ********************************
    // faults, reported with the instruction
    // ********************************
    if (instr_issue) begin
      n.hard_fault = !r.t;
      n.undef_fault = instr_is_cp;
    end
    // irq sampled late: no fixed relation to the instruction stream
    n.irq_sync = {r.irq_sync[1:0], irq_in};
    if (r.irq_sync[2] == r.irq_sync[1]) begin
      n.irq_pend = r.irq_sync[2];
    end

    // ********************************
    // adder and flags
    // ********************************
    if (add_en) begin
      n.add_res = add_out[31:0];
      n.add_c = add_out[33];
      n.add_v = add_out[32];
    end

    // ********************************
    // bus write side
    // ********************************
    unique case (r.wst)
      WR_COLLECT: begin
        if (s_axi_awvalid && r.awready) begin
          n.aw_got = 1'b1;
          n.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
          n.w_got = 1'b1;
          n.wdata = s_axi_wdata;
          n.wstrb = s_axi_wstrb;
        end
        if (n.aw_got && n.w_got) begin
          n.wst = WR_RESP;
          n.bvalid = 1'b1;
          n.bresp = map_hit(n.waddr) ? CRF_RESP_OKAY : CRF_RESP_SLVERR;
          // reserved bits are dropped; software keeps its own copy
          if (n.waddr == CRF_OFS_FLAGS && n.wstrb[3]) begin
            n.nzcv = n.wdata[CRF_N_POS:CRF_V_POS];
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          n.bvalid = 1'b0;
          n.aw_got = 1'b0;
          n.w_got = 1'b0;
          n.wst = WR_COLLECT;
        end
      end
    endcase
    n.awready = (n.wst == WR_COLLECT) && !n.aw_got;
    n.wready = (n.wst == WR_COLLECT) && !n.w_got;

    // datapath flag update overrides a same-cycle software write
    if (add_en && add_set_flags) begin
      n.nzcv[3] = add_out[31];
      n.nzcv[2] = (add_out[31:0] == 32'h0000_0000);
      n.nzcv[1] = add_out[33];
      n.nzcv[0] = add_out[32];
    end else if (logic_flag_en) begin
      n.nzcv[3] = logic_res[31];
      n.nzcv[2] = (logic_res == 32'h0000_0000);
      n.nzcv[1] = logic_c;
    end

    // ********************************
    // bus read side
    // ********************************
    if (r.rvalid) begin
      if (s_axi_rready) begin
        n.rvalid = 1'b0;
        n.arready = 1'b1;
      end
    end else if (r.arready && s_axi_arvalid) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = map_hit(s_axi_araddr) ? CRF_RESP_OKAY : CRF_RESP_SLVERR;
      n.rdata = 32'h0000_0000;
      if (s_axi_araddr == CRF_OFS_FLAGS) begin
        n.rdata[CRF_N_POS:CRF_V_POS] = r.nzcv;
      end else if (s_axi_araddr == CRF_OFS_PC) begin
        n.rdata = r.pc;
      end else if (s_axi_araddr == CRF_OFS_STATE) begin
        n.rdata[1:0] = {r.irq_pend, r.t};
      end else if (map_hit(s_axi_araddr)) begin
        n.rdata = core_read(r, s_axi_araddr[5:2]);
      end
    end else begin
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.regs[CRF_IDX_SP] <= CRF_RST_SP;
      r.pc <= CRF_RST_PC;
      r.t <= CRF_RST_T;
      r.nzcv <= CRF_RST_FLAGS;
      r.wst <= WR_COLLECT;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign rd_data = r.rd_data;
  assign program_counter_reg = r.pc;
  assign stack_pointer_reg = r.regs[CRF_IDX_SP];
  assign return_link_reg = r.regs[CRF_IDX_LR];
  assign program_status_flags = r.nzcv;
  assign execution_state_bit = r.t;
  assign add_res = r.add_res;
  assign add_c = r.add_c;
  assign add_v = r.add_v;
  assign exception_return_start = r.exc_ret;
  assign exc_ret_addr = r.exc_ret_addr;
  assign hard_fault_exception = r.hard_fault;
  assign undef_fault = r.undef_fault;
  assign irq_pending = r.irq_pend;

  // ********************************
  // checks
  // ********************************
  property p_sub_cin_set;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && add_en && add_req.inv_y && add_req.cin) |=>
      (add_res == $past(add_req.x) - $past(add_req.y)) && (add_c == ($past(add_req.x) >= $past(add_req.y)));
  endproperty
  a_sub_cin_set: assert property (p_sub_cin_set) else $error("subtract with carry set wrong");

  property p_sub_cin_clr;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && add_en && add_req.inv_y && !add_req.cin) |=>
      (add_res == $past(add_req.x) - $past(add_req.y) - 32'h0000_0001) &&
      (add_c == ($past(add_req.x) > $past(add_req.y)));
  endproperty
  a_sub_cin_clr: assert property (p_sub_cin_clr) else $error("subtract with carry clear wrong");

  property p_reset_sp_pc;
    @(posedge aclk) $rose(aresetn) |-> (stack_pointer_reg == CRF_RST_SP) && (program_counter_reg == CRF_RST_PC);
  endproperty
  a_reset_sp_pc: assert property (p_reset_sp_pc) else $error("reset values of sp or pc wrong");

  property p_no_pc_index_write;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && wr_en && wr_idx == CRF_IDX_PC && !pc_wr_en) |=> $stable(program_counter_reg);
  endproperty
  a_no_pc_index_write: assert property (p_no_pc_index_write) else $error("index 15 write moved pc");

  property p_plain_branch;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && pc_wr_en && (pc_wr_kind == PCW_PLAIN || pc_wr_kind == PCW_ALU)) |=>
      (program_counter_reg == {$past(pc_wr_addr[31:1]), 1'b0}) && $stable(execution_state_bit);
  endproperty
  a_plain_branch: assert property (p_plain_branch) else $error("plain branch wrong");

  property p_exc_return;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && pc_wr_en && pc_wr_kind == PCW_BX && handler_mode && pc_wr_addr[31:28] == CRF_EXC_NIB) |=>
      exception_return_start && (exc_ret_addr == $past(pc_wr_addr[27:0])) && $stable(program_counter_reg);
  endproperty
  a_exc_return: assert property (p_exc_return) else $error("exception return not started");

  property p_link_branch;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && pc_wr_en && pc_wr_kind == PCW_BLX) |=>
      !exception_return_start && (execution_state_bit == $past(pc_wr_addr[0]));
  endproperty
  a_link_branch: assert property (p_link_branch) else $error("link branch wrong");

  property p_zero_flag;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && add_en && add_set_flags) |=>
      (program_status_flags[2] == (add_res == 32'h0000_0000)) && (program_status_flags[3] == add_res[31]);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("n or z flag wrong");

  property p_overflow;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && add_en && add_req.inv_y == 1'b0) |=>
      add_v == (($past(add_req.x[31]) == $past(add_req.y[31])) && (add_res[31] != $past(add_req.x[31])));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow wrong");

endmodule

//--- src/crf_pkg.sv
package crf_pkg;

  // ********************************
  // reset values and indices
  // ********************************
  localparam logic [31:0] CRF_RST_SP = 32'h2000_1000;
  localparam logic [31:0] CRF_RST_PC = 32'h0000_0100;
  localparam logic CRF_RST_T = 1'b1;
  localparam logic [3:0] CRF_RST_FLAGS = 4'h0;
  localparam logic [3:0] CRF_IDX_SP = 4'hd;
  localparam logic [3:0] CRF_IDX_LR = 4'he;
  localparam logic [3:0] CRF_IDX_PC = 4'hf;
  localparam logic [3:0] CRF_EXC_NIB = 4'hf;
  localparam int CRF_NREG = 15;

  // ********************************
  // flag field positions
  // ********************************
  localparam int CRF_N_POS = 31;
  localparam int CRF_Z_POS = 30;
  localparam int CRF_C_POS = 29;
  localparam int CRF_V_POS = 28;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [11:0] CRF_OFS_FLAGS = 12'h000;
  localparam logic [11:0] CRF_OFS_PC = 12'h004;
  localparam logic [11:0] CRF_OFS_STATE = 12'h008;
  localparam logic [11:0] CRF_OFS_CORE = 12'h040;
  localparam logic [1:0] CRF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CRF_RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    PCW_PLAIN = 5'h01,
    PCW_BX = 5'h02,
    PCW_BLX = 5'h04,
    PCW_LOAD = 5'h08,
    PCW_ALU = 5'h10
  } crf_pcw_type;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP = 2'h2
  } crf_wst_type;

  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic inv_y;
    logic cin;
  } crf_add_req_type;

  typedef struct packed {
    logic [CRF_NREG-1:0][31:0] regs;
    logic [31:0] pc;
    logic [3:0] nzcv;
    logic t;
    logic [31:0] rd_data;
    logic [31:0] add_res;
    logic add_c;
    logic add_v;
    logic exc_ret;
    logic [27:0] exc_ret_addr;
    logic hard_fault;
    logic undef_fault;
    logic [2:0] irq_sync;
    logic irq_pend;
    crf_wst_type wst;
    logic aw_got;
    logic w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crf_state_type;

endpackage

//--- tb/core_registers_status_flags_tb_top.sv
`timescale 1ns/1ps
module core_registers_status_flags_tb_top
  import crf_pkg::*;
;
  logic aclk, aresetn, clk_en, irq_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb, rd_idx, wr_idx, program_status_flags;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data, wr_data, link_val, exc_lr_val, pc_wr_addr, add_res;
  logic [31:0] program_counter_reg, stack_pointer_reg, return_link_reg;
  logic wr_en, link_en, exc_entry_en, pc_wr_en, handler_mode, add_en, add_set_flags, instr_issue, instr_is_cp;
  logic execution_state_bit, add_c, add_v, exception_return_start, hard_fault_exception, undef_fault, irq_pending;
  logic [27:0] exc_ret_addr;
  crf_pcw_type pc_wr_kind;
  crf_add_req_type add_req;
  logic logic_flag_en = 1'h0;
  logic [31:0] logic_res = 32'h0;
  logic logic_c = 1'h0;
  int fail_count = 0;
  int cmp_count = 0;
  logic [65:0] add_tbl [8] = '{{32'h5, 32'h3, 2'h3}, {32'h3, 32'h5, 2'h3}, {32'h5, 32'h5, 2'h2},
    {32'h5, 32'h5, 2'h3}, {32'h8000_0000, 32'h1, 2'h3}, {32'h6, 32'h5, 2'h2},
    {32'hffff_ffff, 32'h1, 2'h0}, {32'h7fff_ffff, 32'h1, 2'h0}};

  crf_core_regs u_crf_core_regs (.*);
  crf_exec_model u_crf_exec_model (.*);

  // ********
  // clock, checks, bus
  // ********
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  task automatic close_out;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    chk("rresp", {30'h0, a == 12'hffc ? CRF_RESP_SLVERR : CRF_RESP_OKAY}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'h0;
  endtask
  task automatic rd_exp(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, d);
    chk("rdata", e, d);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    #1;
    chk("sp", CRF_RST_SP, stack_pointer_reg);
    chk("pc", CRF_RST_PC, program_counter_reg);
    chk("t", {31'h0, CRF_RST_T}, {31'h0, execution_state_bit});
    chk("lr", 32'h0, return_link_reg);
    rd_exp(CRF_OFS_FLAGS, 32'h0);
  endtask
  task automatic t_regs;
    logic [31:0] e;
    for (int i = 0; i < 16; i++) u_crf_exec_model.op_reg(3'h1, i[3:0], 32'hc0de_0000 + i);
    for (int i = 0; i < 16; i++) begin
      e = (i == 15) ? CRF_RST_PC : 32'hc0de_0000 + i;
      @(posedge aclk);
      rd_idx <= i[3:0];
      @(posedge aclk);
      #1;
      chk("rd_data", e, rd_data);
      rd_exp(CRF_OFS_CORE + 12'(4 * i), e);
    end
    chk("sp", 32'hc0de_000d, stack_pointer_reg);
    chk("lr", 32'hc0de_000e, return_link_reg);
  endtask
  task automatic t_link;
    u_crf_exec_model.op_reg(3'h2, 4'h0, 32'h1111_2222);
    #1;
    chk("lr", 32'h1111_2222, return_link_reg);
    u_crf_exec_model.op_reg(3'h7, 4'he, 32'h3333_4444);
    #1;
    chk("lr", 32'hcccc_bbbb, return_link_reg);
    @(posedge aclk);
    clk_en <= 1'h0;
    u_crf_exec_model.op_reg(3'h1, 4'hd, 32'h0);
    #1;
    chk("sp", 32'hc0de_000d, stack_pointer_reg);
    @(posedge aclk);
    clk_en <= 1'h1;
  endtask
  task automatic t_add;
    logic [31:0] x, y, yy;
    logic inv, cin, c, v;
    logic [32:0] s;
    for (int i = 0; i < 8; i++) begin
      {x, y, inv, cin} = add_tbl[i];
      u_crf_exec_model.op_add(x, y, inv, cin);
      #1;
      yy = inv ? ~y : y;
      s = {1'h0, x} + {1'h0, yy} + 33'(cin);
      c = inv ? (cin ? x >= y : x > y) : s[32];
      v = (x[31] == yy[31]) && (s[31] != x[31]);
      chk("add_res", s[31:0], add_res);
      chk("add_c", {31'h0, c}, {31'h0, add_c});
      chk("add_v", {31'h0, v}, {31'h0, add_v});
      chk("flags", {28'h0, s[31], s[31:0] == 32'h0, c, v}, {28'h0, program_status_flags});
    end
  endtask
  // logic result updates n, z, c and leaves v from the last add
  task automatic t_logic;
    @(posedge aclk);
    {logic_flag_en, logic_res, logic_c} <= {1'h1, 32'h0, 1'h1};
    @(posedge aclk);
    logic_flag_en <= 1'h0;
    #1;
    chk("flags", 32'h7, {28'h0, program_status_flags});
  endtask
  task automatic t_bus;
    logic [31:0] d;
    axi_rd(CRF_OFS_FLAGS, d);
    chk("flags_rd", 32'h7000_0000, d);
    // reserved bits go back exactly as read
    axi_wr(CRF_OFS_FLAGS, {4'h6, d[27:0]}, CRF_RESP_OKAY);
    chk("flags", 32'h6, {28'h0, program_status_flags});
    axi_wr(CRF_OFS_PC, 32'h0, CRF_RESP_OKAY);
    chk("pc", CRF_RST_PC, program_counter_reg);
    axi_wr(12'hffc, 32'h1, CRF_RESP_SLVERR);
    rd_exp(12'hffc, 32'h0);
    rd_exp(CRF_OFS_STATE, 32'h1);
  endtask
  task automatic pc_step(input crf_pcw_type k, input logic [31:0] a, input logic h, input logic x,
                         input logic [31:0] p, input logic t);
    u_crf_exec_model.op_pc(k, a, h);
    #1;
    chk("exc_ret", {31'h0, x}, {31'h0, exception_return_start});
    if (x) chk("exc_addr", {4'h0, a[27:0]}, {4'h0, exc_ret_addr});
    chk("pc", p, program_counter_reg);
    chk("t", {31'h0, t}, {31'h0, execution_state_bit});
  endtask
  task automatic t_pc;
    pc_step(PCW_PLAIN, 32'h0000_0201, 1'h0, 1'h0, 32'h200, 1'h1);
    pc_step(PCW_ALU, 32'h0000_0303, 1'h1, 1'h0, 32'h302, 1'h1);
    pc_step(PCW_BX, 32'hffff_fff9, 1'h1, 1'h1, 32'h302, 1'h1);
    pc_step(PCW_LOAD, 32'hffff_fff1, 1'h1, 1'h1, 32'h302, 1'h1);
    pc_step(PCW_BLX, 32'hf000_0401, 1'h1, 1'h0, 32'hf000_0400, 1'h1);
    pc_step(PCW_BX, 32'hf000_0501, 1'h0, 1'h0, 32'hf000_0500, 1'h1);
    pc_step(PCW_LOAD, 32'h0000_0700, 1'h0, 1'h0, 32'h700, 1'h0);
    pc_step(PCW_PLAIN, 32'h0000_0801, 1'h0, 1'h0, 32'h800, 1'h0);
    u_crf_exec_model.op_issue(1'h0);
    #1;
    chk("hard_fault", 32'h1, {31'h0, hard_fault_exception});
    pc_step(PCW_BLX, 32'h0000_0901, 1'h0, 1'h0, 32'h900, 1'h1);
    u_crf_exec_model.op_issue(1'h1);
    #1;
    chk("hard_fault", 32'h0, {31'h0, hard_fault_exception});
    chk("undef", 32'h1, {31'h0, undef_fault});
  endtask
  task automatic t_irq;
    @(posedge aclk);
    irq_in <= 1'h1;
    for (int k = 0; k < 8 && irq_pending !== 1'h1; k++) @(posedge aclk);
    #1;
    chk("irq", 32'h1, {31'h0, irq_pending});
    rd_exp(CRF_OFS_STATE, 32'h3);
    @(posedge aclk);
    irq_in <= 1'h0;
  endtask

  initial begin
    {aresetn, clk_en, irq_in, rd_idx} = 7'h20;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_regs;
    t_link;
    t_add;
    t_logic;
    t_bus;
    t_pc;
    t_irq;
    close_out;
  end
  // whole run needs well under 3000 cycles
  initial begin
    #(4 * 20000);
    fail_count++;
    close_out;
  end
endmodule

//--- tb/crf_exec_model.sv
`timescale 1ns/1ps
module crf_exec_model
  import crf_pkg::*;
(
  input wire logic aclk,
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic [31:0] wr_data,
  output logic link_en,
  output logic [31:0] link_val,
  output logic exc_entry_en,
  output logic [31:0] exc_lr_val,
  output logic pc_wr_en,
  output crf_pcw_type pc_wr_kind,
  output logic [31:0] pc_wr_addr,
  output logic handler_mode,
  output logic add_en,
  output crf_add_req_type add_req,
  output logic add_set_flags,
  output logic instr_issue,
  output logic instr_is_cp
);
  // ********
  // requests held for one sampling edge
  // ********
  initial begin
    {wr_en, link_en, exc_entry_en, pc_wr_en, add_en, add_set_flags, instr_issue, instr_is_cp} = 8'h0;
    {handler_mode, wr_idx, wr_data, link_val, exc_lr_val, pc_wr_addr} = 133'h0;
    pc_wr_kind = PCW_PLAIN;
    add_req = '0;
  end
  task automatic op_reg(input logic [2:0] sel, input logic [3:0] idx, input logic [31:0] d);
    @(posedge aclk);
    {exc_entry_en, link_en, wr_en} <= sel;
    wr_idx <= idx;
    wr_data <= d;
    link_val <= d;
    // inverted so the winner of a clash is visible
    exc_lr_val <= ~d;
    @(posedge aclk);
    {exc_entry_en, link_en, wr_en} <= 3'h0;
  endtask
  task automatic op_pc(input crf_pcw_type k, input logic [31:0] a, input logic h);
    @(posedge aclk);
    pc_wr_kind <= k;
    pc_wr_addr <= a;
    handler_mode <= h;
    pc_wr_en <= 1'h1;
    @(posedge aclk);
    pc_wr_en <= 1'h0;
  endtask
  task automatic op_add(input logic [31:0] x, input logic [31:0] y, input logic inv, input logic cin);
    @(posedge aclk);
    add_req <= {x, y, inv, cin};
    {add_en, add_set_flags} <= 2'h3;
    @(posedge aclk);
    {add_en, add_set_flags} <= 2'h0;
  endtask
  task automatic op_issue(input logic cp);
    @(posedge aclk);
    {instr_issue, instr_is_cp} <= {1'h1, cp};
    @(posedge aclk);
    {instr_issue, instr_is_cp} <= 2'h0;
  endtask
endmodule
